// ==== pkg/wdr_defines.vh ====
`ifndef WDR_DEFINES_VH
`define WDR_DEFINES_VH

// register indices as printed; byte address is four times the index
`define WDR_IDX_PRESCALE_CTRL   16'h0081
`define WDR_IDX_PRESCALE_ALIAS  16'h0181
`define WDR_IDX_CONFIG_WORD     16'h2007
`define WDR_IDX_STATUS          16'h0003
`define WDR_ADDR_WIDTH          18

// timer_prescale_ctrl fields
`define WDR_PRE_ASSIGN_BIT      3
`define WDR_PRE_SEL_MSB         2
`define WDR_PRE_SEL_LSB         0
`define WDR_PRESCALE_RESET      8'hff

// device_config_word fields
`define WDR_CFG_ENABLE_BIT      3
`define WDR_CONFIG_RESET        8'hff

// status fields
`define WDR_STAT_FLAG_BIT       0
`define WDR_STAT_RUN_BIT        1

// base time-out in rc oscillator periods
`define WDR_BASE_RC_TICKS       16'h0100

`endif

// ==== logic/wdr_postscaler.v ====
`timescale 1ns/1ps
`include "wdr_defines.vh"

module wdr_postscaler #(
  parameter integer CNT_WIDTH = 7
) (
  // clock and reset
  input  wire       clk_i,
  input  wire       arst_n_i,
  // control
  input  wire       clear_i,
  input  wire       base_tick_i,
  input  wire       assigned_i,
  input  wire [2:0] sel_i,
  // result
  output reg        expire_o
);

  reg  [CNT_WIDTH-1:0] count_q;
  wire [CNT_WIDTH-1:0] limit;

  // ratio is 2**sel, so the last count is 2**sel - 1
  assign limit = (({{(CNT_WIDTH-1){1'b0}}, 1'b1}) << sel_i) - {{(CNT_WIDTH-1){1'b0}}, 1'b1};

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_q  <= {CNT_WIDTH{1'b0}};
      expire_o <= 1'b0;
    end else begin
      expire_o <= 1'b0;
      if (clear_i) begin
        count_q <= {CNT_WIDTH{1'b0}}; // [RQ7]
      end else if (base_tick_i) begin
        if (!assigned_i || count_q >= limit) begin
          count_q  <= {CNT_WIDTH{1'b0}};
          expire_o <= 1'b1; // [RQ8]
        end else begin
          count_q <= count_q + {{(CNT_WIDTH-1){1'b0}}, 1'b1}; // [RQ8]
        end
      end
    end
  end

endmodule // wdr_postscaler

// ==== logic/wdr_top.v ====
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "wdr_defines.vh"

// Summary of operation
// RQ1 - counting is paced by the free-running rc oscillator, also during sleep
// RQ2 - expiry while running normally pulses the watchdog reset output
// RQ3 - expiry while asleep pulses wake-up instead of reset
// RQ4 - every expiry clears the active-low time-out flag
// RQ5 - enable fuse bit 3 of the config word at zero disables it for good
// RQ6 - assignment bit and select bits 2..0 of the prescale register pick the ratio
// RQ7 - sleep instruction clears counter and assigned postscaler, restarting the period
// RQ8 - with assignment, interval equals base time-out times the selected ratio
module wdr_top #(
  parameter [15:0] BASE_TICKS = `WDR_BASE_RC_TICKS
) (
  // clock and reset
  input  wire                       clk_i,
  input  wire                       arst_n_i,
  // rc oscillator pin
  input  wire                       rc_osc_i,
  // cpu events
  input  wire                       sleep_exec_i,
  input  wire                       clear_exec_i,
  input  wire                       cpu_asleep_i,
  // apb slave
  input  wire                       psel_i,
  input  wire                       penable_i,
  input  wire                       pwrite_i,
  input  wire [`WDR_ADDR_WIDTH-1:0] paddr_i,
  input  wire [31:0]                pwdata_i,
  output reg  [31:0]                prdata_o,
  output reg                        pready_o,
  output reg                        pslverr_o,
  // watchdog results
  output reg                        wdt_reset_o,
  output reg                        wake_o,
  output reg                        timeout_flag_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // software visible state
  reg  [7:0]  prescale_q;
  reg  [7:0]  config_q;

  // timing chain
  reg  [2:0]  rc_sync_q;
  reg  [15:0] base_cnt_q;
  reg         base_tick_q;

  // read mux outputs, combinational
  reg  [31:0] rdata_d;
  reg         hit_d;

  // derived controls
  wire        rc_edge;
  wire        enabled;
  wire        restart;
  wire        expire;
  wire        setup;
  wire        wr_take;
  wire        refuse;
  wire [7:0]  cfg_keep;
  wire [15:0] idx;

  // bus decode; the two low address bits are ignored, registers are words
  assign idx     = paddr_i[`WDR_ADDR_WIDTH-1:2];
  assign setup   = psel_i & ~penable_i;
  assign wr_take = psel_i & penable_i & pready_o & pwrite_i;
  assign refuse  = ~hit_d | (pwrite_i & (idx == `WDR_IDX_STATUS));

  // watchdog control; every restart source clears both counter stages
  assign enabled  = config_q[`WDR_CFG_ENABLE_BIT]; // [RQ5]
  assign restart  = sleep_exec_i | clear_exec_i | ~enabled;
  // the fuse bit may only be cleared by a write, never set again
  assign cfg_keep = {4'hf, config_q[`WDR_CFG_ENABLE_BIT], 3'h7}; // [RQ5]

  ////////////////////////////////////////////////////////////////////////////
  // rc oscillator: two flops before anything looks at it, third for the edge
  // the oscillator pin is the only input from another clock domain
  // stage 0 may be metastable, so only stage 1 ever reads it
  // each rc half period must span at least two clk periods, or an edge is lost
  // the stages reset low like an idle pin; a pin idling high gives one early edge

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rc_sync_q <= 3'h0;
    end else begin
      rc_sync_q <= {rc_sync_q[1:0], rc_osc_i}; // [RQ1]
    end
  end

  // one-cycle strobe per rising rc edge
  assign rc_edge = rc_sync_q[1] & ~rc_sync_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // base time-out counter, paced only by the rc edge, so cpu sleep does not stop it
  // a cleared fuse holds the count at zero, so nothing stale can ever expire
  // the reset pulse restarts the count too, as the device restart it causes would
  // >= rather than == keeps the wrap safe should the count ever start above the end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      base_cnt_q  <= 16'h0000;
      base_tick_q <= 1'b0;
    end else begin
      base_tick_q <= 1'b0;
      if (restart || wdt_reset_o) begin
        base_cnt_q <= 16'h0000; // [RQ7]
      end else if (rc_edge) begin
        if (base_cnt_q >= BASE_TICKS - 16'h0001) begin
          base_cnt_q  <= 16'h0000;
          base_tick_q <= 1'b1; // [RQ1]
        end else begin
          base_cnt_q <= base_cnt_q + 16'h0001; // [RQ1]
        end
      end
    end
  end

  // the postscaler only divides base ticks; with the assignment bit low every
  // base tick expires, a ratio of one, and the select bits are ignored
  // the whole expiry path is three registered stages after the synced rc edge
  wdr_postscaler #(
    .CNT_WIDTH (7)
  ) u_post (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .clear_i     (restart | wdt_reset_o), // [RQ7]
    .base_tick_i (base_tick_q),
    .assigned_i  (prescale_q[`WDR_PRE_ASSIGN_BIT]), // [RQ6]
    .sel_i       (prescale_q[`WDR_PRE_SEL_MSB:`WDR_PRE_SEL_LSB]), // [RQ6]
    .expire_o    (expire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // expiry outcome; expiry beats a same-cycle re-arm of the flag
  // cpu_asleep_i is taken in the expiry cycle, so a sleep entered exactly then
  // already turns the reset into a wake-up
  // both pulses last one cycle; the flag stays low until a sleep or clear re-arms it

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wdt_reset_o      <= 1'b0;
      wake_o           <= 1'b0;
      timeout_flag_n_o <= 1'b1;
    end else begin
      wdt_reset_o <= expire & enabled & ~cpu_asleep_i; // [RQ2]
      wake_o      <= expire & enabled & cpu_asleep_i; // [RQ3]
      if (expire && enabled) begin
        timeout_flag_n_o <= 1'b0; // [RQ4]
      end else if (sleep_exec_i || clear_exec_i) begin
        timeout_flag_n_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb: ready one cycle after setup, data captured at setup
  // read data is latched in the setup cycle, so it cannot move under the master
  // during the access cycle; pready_o is already high in the first access cycle, so no wait state is added
  // unmapped indices read zero and answer with an error

  always @* begin
    rdata_d = 32'h0000_0000;
    hit_d   = 1'b1;
    case (idx)
      `WDR_IDX_PRESCALE_CTRL,
      `WDR_IDX_PRESCALE_ALIAS: begin
        rdata_d[7:0] = prescale_q;
      end
      `WDR_IDX_CONFIG_WORD: begin
        rdata_d[7:0] = config_q;
      end
      `WDR_IDX_STATUS: begin
        rdata_d[`WDR_STAT_FLAG_BIT] = timeout_flag_n_o;
        rdata_d[`WDR_STAT_RUN_BIT]  = enabled;
      end
      default: begin
        hit_d = 1'b0;
      end
    endcase
  end

  // pready_o follows each setup by one cycle; pslverr_o clears once psel_i drops
  // a write to the read-only status word is refused, with no effect
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= setup;
      if (setup) begin
        prdata_o  <= pwrite_i ? 32'h0000_0000 : rdata_d;
        pslverr_o <= refuse;
      end else if (!psel_i) begin
        pslverr_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes; a cleared enable fuse can never be set again
  // writes land only at the access edge that pready_o qualifies
  // the alias index decodes to the same storage, so both offsets read back alike

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prescale_q <= `WDR_PRESCALE_RESET;
      config_q   <= `WDR_CONFIG_RESET;
    end else if (wr_take) begin
      if (idx == `WDR_IDX_PRESCALE_CTRL || idx == `WDR_IDX_PRESCALE_ALIAS) begin
        prescale_q <= pwdata_i[7:0]; // [RQ6]
      end
      if (idx == `WDR_IDX_CONFIG_WORD) begin
        config_q <= pwdata_i[7:0] & cfg_keep; // [RQ5]
      end
    end
  end

endmodule // wdr_top

// ==== tb/wdr_top_properties.sv ====
`timescale 1ns/1ps
`include "wdr_defines.vh"
module wdr_top_chk (
  input wire logic clk_i, arst_n_i, rc_osc_i, sleep_exec_i, clear_exec_i, cpu_asleep_i,
  input wire logic psel_i, penable_i, pwrite_i, pready_o, wdt_reset_o, wake_o, timeout_flag_n_o,
  input wire logic [`WDR_ADDR_WIDTH-1:0] paddr_i,
  input wire logic [31:0] pwdata_i
);
  logic       rc_q;
  logic       off_q;
  logic [3:0] age_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // cycles since the last rc rise, saturating so a stalled oscillator never wraps
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rc_q <= 1'b0;
      off_q <= 1'b0;
      age_q <= 4'hf;
    end else begin
      rc_q <= rc_osc_i;
      age_q <= (rc_osc_i & ~rc_q) ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
      if (psel_i & penable_i & pready_o & pwrite_i & ~pwdata_i[3] &
          paddr_i == {`WDR_IDX_CONFIG_WORD, 2'b00}) begin
        off_q <= 1'b1;
      end
    end
  end
  ////////////////////
  AST_APB_READY: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready");
  AST_READY_CAUSE: assert property (pready_o |-> $past(psel_i && !penable_i))
    else $error("stray ready");
  AST_RST_AWAKE: assert property (wdt_reset_o |-> !$past(cpu_asleep_i) && !wake_o)
    else $error("reset while asleep");
  AST_WAKE_ASLEEP: assert property (wake_o |-> $past(cpu_asleep_i))
    else $error("wake while running");
  AST_FLAG_LOW: assert property (wdt_reset_o || wake_o |-> !timeout_flag_n_o)
    else $error("flag not cleared");
  AST_FLAG_FALL: assert property ($fell(timeout_flag_n_o) |-> wdt_reset_o || wake_o)
    else $error("flag fell alone");
  AST_FLAG_RISE:
    assert property ($rose(timeout_flag_n_o) |-> $past(sleep_exec_i || clear_exec_i))
    else $error("flag rose alone");
  AST_ONE_PULSE: assert property (wdt_reset_o || wake_o |=> !(wdt_reset_o || wake_o))
    else $error("long pulse");
  AST_RC_PACED: assert property (wdt_reset_o || wake_o |-> age_q >= 4'h2 && age_q <= 4'h8)
    else $error("expiry off rc edge");
  AST_FUSE_OFF: assert property ($past(off_q, 4) |-> !(wdt_reset_o || wake_o))
    else $error("expiry while disabled");
  cover property (wake_o);
  cover property (wdt_reset_o);
  cover property ($rose(timeout_flag_n_o));
endmodule // wdr_top_chk
bind wdr_top wdr_top_chk u_chk (.*);

// ==== tb/test_watchdog_timer_rc.sv ====
`timescale 1ns/1ps
`include "wdr_defines.vh"
module test_watchdog_timer_rc;
  localparam int BT = 4;
  localparam logic [17:0] A_PRE = {`WDR_IDX_PRESCALE_CTRL, 2'b00};
  localparam logic [17:0] A_ALI = {`WDR_IDX_PRESCALE_ALIAS, 2'b00};
  localparam logic [17:0] A_CFG = {`WDR_IDX_CONFIG_WORD, 2'b00};
  localparam logic [17:0] A_STA = {`WDR_IDX_STATUS, 2'b00};
  logic        clk_i = 0, arst_n_i = 0, rc_osc_i = 0, cpu_asleep_i = 0;
  logic        sleep_exec_i = 0, clear_exec_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [17:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, wd;
  logic        pready_o, pslverr_o, wdt_reset_o, wake_o, timeout_flag_n_o, slp;
  logic [3:0]  ph = 0;
  logic [39:0] q[$];
  int          err_total = 0, n_checks = 0, rcn = 0;
  wdr_top #(.BASE_TICKS(16'h0004)) u_dut (.*);
  initial forever #2.5 clk_i = ~clk_i;
  // rc pin: 16 clk period, unrelated to any bus activity
  always @(posedge clk_i) begin
    ph <= ph + 4'h1;
    rc_osc_i <= ph[3];
  end
  ////////////////////
  task chk(input logic [39:0] g, input logic [39:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task final_report;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [39:0] e);
    q.push_back(e);
    psel_i <= 1;
    penable_i <= 0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    @(posedge clk_i iff pready_o);
    psel_i <= 0;
    penable_i <= 0;
    @(posedge clk_i);
  endtask
  // restart lands at ph 0, far from a synced rc edge, so the count is unambiguous
  task pulse(input logic sl);
    @(posedge clk_i iff ph == 4'hf);
    sleep_exec_i <= sl;
    clear_exec_i <= !sl;
    @(posedge clk_i);
    sleep_exec_i <= 0;
    clear_exec_i <= 0;
  endtask
  ////////////////////
  always @(posedge clk_i) begin
    if (ph == 4'hc) rcn++;
    if (sleep_exec_i || clear_exec_i) rcn = 0;
    if (psel_i && penable_i && pready_o)
      chk({7'h0, pslverr_o, pwrite_i ? 32'h0 : prdata_o}, q.size() ? q.pop_front() : '1);
    if (wdt_reset_o || wake_o) begin
      chk({8'h0, rcn[28:0], wake_o, wdt_reset_o, timeout_flag_n_o},
          q.size() ? q.pop_front() : '1);
      rcn = 0;
    end
  end
  initial begin
    #400000;
    err_total++;
    final_report;
  end
  initial begin
    void'($urandom(94));
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1;
    @(posedge clk_i);
    apb(0, A_PRE, 0, 40'hff);
    apb(0, A_CFG, 0, 40'hff);
    apb(0, A_STA, 0, 40'h3);
    apb(0, 18'h4, 0, 40'h1_0000_0000);
    apb(1, A_STA, 0, 40'h1_0000_0000);
    for (int s = 0; s < 9; s++) begin
      wd = $urandom;
      wd[3:0] = {s < 8, s[2:0]};
      slp = $urandom_range(1);
      apb(1, s[0] ? A_ALI : A_PRE, wd, 40'h0);
      apb(0, A_PRE, 0, {32'h0, wd[7:0]});
      cpu_asleep_i <= slp;
      q.push_back({8'h0, 29'(BT << (s < 8 ? s : 0)), slp, !slp, 1'b0});
      pulse(s[0]);
      wait (q.size() == 0);
      apb(0, A_STA, 0, 40'h2);
    end
    wd = $urandom;
    wd[3] = 0;
    apb(1, A_CFG, wd, 40'h0);
    apb(1, A_CFG, 32'hff, 40'h0);
    apb(0, A_CFG, 0, 40'hf7);
    pulse(0);
    apb(0, A_STA, 0, 40'h1);
    repeat (2000) @(posedge clk_i);
    final_report;
  end
endmodule // test_watchdog_timer_rc
